// ===== include/rpv_pkg.sv
package rpv_pkg;
	localparam int LANES = 4;
	localparam int IDX_W = 6;
	// Printed offsets are register indices; byte address is index * 4
	localparam logic [5:0] IDX_CTRL = 6'h10;
	localparam logic [5:0] IDX_CPLO = 6'h11;
	localparam logic [5:0] IDX_CPMID = 6'h12;
	localparam logic [5:0] IDX_CPTOP = 6'h13;
	localparam logic [5:0] IDX_THR = 6'h14;
	localparam logic [5:0] IDX_IRQC = 6'h15;
	localparam logic [5:0] IDX_LOAD = 6'h20;
	localparam logic [5:0] IDX_LSTAT = 6'h21;
	localparam logic [5:0] IDX_ISTAT = 6'h22;
	localparam logic [5:0] IDX_IEN = 6'h23;
	localparam logic [5:0] IDX_ICLR = 6'h24;
	localparam logic [5:0] IDX_TALLY = 6'h25;
	localparam logic [7:0] RST_VAL = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hBF;
	localparam logic [7:0] CPTOP_WMASK = 8'h0F;
	localparam logic [7:0] THR_WMASK = 8'h07;
	localparam int CTRL_LEN_BIT = 7;
	localparam int ORDER_LSB = 3;
	localparam int IRQC_ALIGN_BIT = 7;
	localparam int ECLR_BIT = 4;
	localparam int ICLR_BIT = 3;
	localparam int ISTAT_ALIGN_BIT = 4;
	localparam logic [2:0] KIND_OFF = 3'h0;
	localparam logic [2:0] KIND_PRBS = 3'h1;
	localparam logic [2:0] KIND_CLOCK = 3'h2;
	localparam logic [2:0] KIND_CUSTOM = 3'h3;
	localparam logic [2:0] SRC_MISMATCH = 3'h0;
	localparam logic [2:0] SRC_SEARCH = 3'h1;
	localparam logic [2:0] SRC_ERROR = 3'h2;
	localparam logic [2:0] SRC_SYNC = 3'h3;
	localparam logic [2:0] SRC_ALIGN = 3'h4;
	localparam logic [19:0] CLK_PATTERN = 20'h003FF;
	localparam logic [19:0] MASK16 = 20'h0FFFF;
	localparam logic [19:0] MASK20 = 20'hFFFFF;
	localparam logic [11:0] TALLY_MAX = 12'hFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic len20;
		logic [2:0] order;
		logic [2:0] kind;
		logic [19:0] pattern;
		logic [2:0] retain;
	} rpv_cfg_t;

	typedef struct packed {
		logic mismatch;
		logic search;
		logic err;
		logic sync;
	} rpv_lstat_t;

	function automatic logic [4:0] rpv_prbs_deg(input logic [2:0] order);
		unique case (order)
			3'h0: return 5'h07;
			3'h1: return 5'h0B;
			3'h2: return 5'h17;
			3'h3: return 5'h1F;
			3'h4, 3'h5: return 5'h0F;
			default: return 5'h14;
		endcase
	endfunction : rpv_prbs_deg

	function automatic logic [4:0] rpv_prbs_tap(input logic [2:0] order);
		unique case (order)
			3'h0: return 5'h06;
			3'h1: return 5'h09;
			3'h2: return 5'h12;
			3'h3: return 5'h1C;
			3'h4, 3'h5: return 5'h0E;
			default: return 5'h03;
		endcase
	endfunction : rpv_prbs_tap
endpackage : rpv_pkg

// ===== core/rpv_lane.sv
module rpv_lane (
	input wire logic clk,
	input wire logic reset,
	input wire logic load,
	input rpv_pkg::rpv_cfg_t cfg_in,
	input wire logic rx_bit,
	input wire logic [19:0] rx_word,
	input wire logic clr_tally,
	output rpv_pkg::rpv_lstat_t stat,
	output logic [11:0] tally
);
	import rpv_pkg::*;

	rpv_cfg_t cfg_r;
	rpv_lstat_t stat_r;
	logic [30:0] hist_r;
	logic [30:0] cnt_r;
	logic [2:0] run_r;
	logic locked_r;
	logic [11:0] tally_r;

	////////////////////////////////////////////////////////////////
	// Settings flow through while load is high, then hold
	wire rpv_cfg_t eff = load ? cfg_in : cfg_r;
	wire logic [4:0] deg = rpv_prbs_deg(eff.order);
	wire logic [4:0] tap = rpv_prbs_tap(eff.order);
	wire logic [30:0] period = 31'((32'h1 << deg) - 32'h1);
	wire logic pred = hist_r[5'(deg - 5'h01)] ^ hist_r[5'(tap - 5'h01)];
	wire logic [19:0] mask = eff.len20 ? MASK20 : MASK16;
	wire logic en = (eff.kind != KIND_OFF) && !eff.kind[2];
	wire logic timing = eff.kind[2];
	wire logic wrap = cnt_r >= 31'(period - 31'h1);
	logic bad;

	always_comb begin
		unique case (eff.kind)
			KIND_PRBS: bad = pred != rx_bit;
			KIND_CLOCK: bad = rx_word != CLK_PATTERN;
			// Top nibble ignored in 16-bit length
			KIND_CUSTOM: bad = |((rx_word ^ eff.pattern) & mask);
			default: bad = 1'b0;
		endcase
	end

	// Lock after retain+1 clean words; any error drops it
	wire logic lock_nxt = en && !bad && (locked_r || run_r == eff.retain);
	wire logic [2:0] run_nxt = (!en || bad) ? 3'h0 :
		(run_r == 3'h7 ? run_r : 3'(run_r + 3'h1));
	wire logic err = en && locked_r && bad;
	wire logic [30:0] cnt_nxt = (!timing || wrap) ? 31'h0 : 31'(cnt_r + 31'h1);
	wire logic [11:0] tally_nxt = clr_tally ? {11'h000, err} :
		((err && tally_r != TALLY_MAX) ? 12'(tally_r + 12'h001) : tally_r);
	wire rpv_lstat_t stat_nxt = '{mismatch: err, search: en && !locked_r,
		err: err, sync: timing && wrap};

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_r <= '0;
			hist_r <= '0;
			cnt_r <= '0;
			run_r <= '0;
			locked_r <= 1'b0;
			stat_r <= '0;
			tally_r <= '0;
		end else begin
			if (load) begin
				cfg_r <= cfg_in;
			end
			hist_r <= {hist_r[29:0], rx_bit};
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
			locked_r <= lock_nxt;
			stat_r <= stat_nxt;
			tally_r <= tally_nxt;
		end
	end

	assign stat = stat_r;
	assign tally = tally_r;

	////////////////////////////////////////////////////////////////
	a_cfg_hold: assert property (@(posedge clk) disable iff (reset)
		!load && $past(!load) |-> cfg_r == $past(cfg_r))
		else $error("lane settings moved while not loading");
	a_custom_16: assert property (@(posedge clk) disable iff (reset)
		eff.kind == KIND_CUSTOM && !eff.len20 && locked_r &&
		rx_word[15:0] == eff.pattern[15:0] |=> !stat_r.mismatch)
		else $error("top nibble compared in 16-bit mode");
	a_off_quiet: assert property (@(posedge clk) disable iff (reset)
		eff.kind == KIND_OFF |=> !stat_r.mismatch && !stat_r.search)
		else $error("disabled lane reports activity");
	a_timing_sync: assert property (@(posedge clk) disable iff (reset)
		stat_r.sync |-> $past(timing))
		else $error("sync pulse outside timing-only mode");
	a_tally_clear: assert property (@(posedge clk) disable iff (reset)
		clr_tally |=> tally_r <= 12'h001)
		else $error("tally not cleared");
	c_lane_lock: cover property (@(posedge clk) disable iff (reset)
		$rose(locked_r));
endmodule : rpv_lane

// ===== core/rpv_top.sv
// Function
// - Length bit picks 16 or 20-bit custom
// - Order field picks PRBS polynomial degree
// - Kind field: off, PRBS, clock, custom
// - Kind top bit: timing-only sync spacing
// - Custom pattern in three parts, nibble conditional
// - Lane alignment done status, low after reset
// - Rising clear bit zeroes error tallies, or sets 1 on a same-cycle error
// - Writing one clears latched test interrupts
// - Interrupt source select, resets to zero
// - Config registers reset to all zeros
// - Load strobe passes settings, then latches
// - Per-lane mismatch and search status bits
// - Latched per-lane interrupt holds until cleared
module rpv_top (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [rpv_pkg::LANES-1:0] rx_bit,
	input wire logic [rpv_pkg::LANES-1:0][19:0] rx_word,
	input wire logic align_pin,
	output logic irq
);
	import rpv_pkg::*;

	////////////////////////////////////////////////////////////////
	// Bus slave state
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic aw_got_r, w_got_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [5:0] waddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic aligned_w_r;

	// Register bank
	logic [7:0] ctrl_r, cplo_r, cpmid_r, cptop_r, thr_r;
	logic [2:0] src_r;
	logic ecc_r, ecc_prev_r, icc_r;
	logic [3:0] load_r;
	logic [3:0] ltirq_r;
	logic [4:0] ien_r, ist_r;
	logic s1_r, s2_r, s3_r, align_r, irq_r;
	logic align_prev_r;

	rpv_lstat_t [LANES-1:0] lstat;
	logic [LANES-1:0][11:0] tally;

	function automatic logic mapped(input logic [5:0] idx);
		return (idx >= IDX_CTRL && idx <= IDX_IRQC) ||
			(idx >= IDX_LOAD && idx <= 6'(IDX_TALLY + 6'h03));
	endfunction : mapped

	////////////////////////////////////////////////////////////////
	// Write path: address and data taken in either order
	wire logic aw_take = awvalid && awready_r;
	wire logic w_take = wvalid && wready_r;
	wire logic wr_do = aw_got_r && w_got_r && !bvalid_r;
	wire logic wr_en = wr_do && wlane_r && aligned_w_r && mapped(waddr_r);
	wire logic aw_got_nxt = (aw_got_r || aw_take) && !wr_do;
	wire logic w_got_nxt = (w_got_r || w_take) && !wr_do;
	wire logic bvalid_nxt = wr_do || (bvalid_r && !bready);
	wire logic wr_ok = aligned_w_r && mapped(waddr_r);
	wire logic [1:0] bresp_nxt = wr_do ? (wr_ok ? RESP_OKAY : RESP_SLVERR)
		: bresp_r;

	// One write outstanding; ready returns after the response
	always_ff @(posedge clk) begin
		if (reset) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			waddr_r <= '0;
			aligned_w_r <= 1'b0;
			wbyte_r <= RST_VAL;
			wlane_r <= 1'b0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awready_r <= !aw_got_nxt && !bvalid_nxt;
			wready_r <= !w_got_nxt && !bvalid_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			if (aw_take) begin
				waddr_r <= awaddr[7:2];
				aligned_w_r <= awaddr[1:0] == 2'h0;
			end
			if (w_take) begin
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read path
	wire logic ar_take = arvalid && arready_r;
	wire logic rvalid_nxt = ar_take || (rvalid_r && !rready);
	wire logic [5:0] ridx = araddr[7:2];
	wire logic rd_ok = araddr[1:0] == 2'h0 && mapped(ridx);
	wire logic [7:0] lstat_byte = {lstat[3].mismatch, lstat[2].mismatch,
		lstat[1].mismatch, lstat[0].mismatch, lstat[3].search,
		lstat[2].search, lstat[1].search, lstat[0].search};
	wire logic [7:0] irqc_byte = {align_r, 2'h0, ecc_r, icc_r, src_r};
	logic [31:0] rmux;

	always_comb begin
		rmux = 32'h00000000;
		unique case (ridx)
			IDX_CTRL: rmux[7:0] = ctrl_r;
			IDX_CPLO: rmux[7:0] = cplo_r;
			IDX_CPMID: rmux[7:0] = cpmid_r;
			IDX_CPTOP: rmux[7:0] = cptop_r;
			IDX_THR: rmux[7:0] = thr_r;
			IDX_IRQC: rmux[7:0] = irqc_byte;
			IDX_LOAD: rmux[7:0] = {ltirq_r, load_r};
			IDX_LSTAT: rmux[7:0] = lstat_byte;
			IDX_ISTAT: rmux[4:0] = ist_r;
			IDX_IEN: rmux[4:0] = ien_r;
			IDX_TALLY: rmux[11:0] = tally[0];
			6'(IDX_TALLY + 6'h01): rmux[11:0] = tally[1];
			6'(IDX_TALLY + 6'h02): rmux[11:0] = tally[2];
			6'(IDX_TALLY + 6'h03): rmux[11:0] = tally[3];
			default: rmux = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else begin
			arready_r <= !rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_take) begin
				rdata_r <= rd_ok ? rmux : 32'h00000000;
				rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Register writes; reserved bits masked off
	wire logic wr_ctrl = wr_en && waddr_r == IDX_CTRL;
	wire logic wr_irqc = wr_en && waddr_r == IDX_IRQC;
	wire logic wr_iclr = wr_en && waddr_r == IDX_ICLR;

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_r <= RST_VAL;
			cplo_r <= RST_VAL;
			cpmid_r <= RST_VAL;
			cptop_r <= RST_VAL;
			thr_r <= RST_VAL;
			src_r <= 3'h0;
			load_r <= 4'h0;
			ien_r <= 5'h00;
		end else if (wr_en) begin
			unique case (waddr_r)
				IDX_CTRL: ctrl_r <= wbyte_r & CTRL_WMASK;
				IDX_CPLO: cplo_r <= wbyte_r;
				IDX_CPMID: cpmid_r <= wbyte_r;
				IDX_CPTOP: cptop_r <= wbyte_r & CPTOP_WMASK;
				IDX_THR: thr_r <= wbyte_r & THR_WMASK;
				IDX_IRQC: src_r <= wbyte_r[2:0];
				IDX_LOAD: load_r <= wbyte_r[3:0];
				IDX_IEN: ien_r <= wbyte_r[4:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Lanes
	wire rpv_cfg_t cfg = '{len20: ctrl_r[CTRL_LEN_BIT],
		order: ctrl_r[ORDER_LSB+:3], kind: ctrl_r[2:0],
		pattern: {cptop_r[3:0], cpmid_r, cplo_r}, retain: thr_r[2:0]};
	// Clear acts on the bit's rising edge only
	wire logic clr_edge = ecc_r && !ecc_prev_r;

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		rpv_lane u_lane (
			.clk(clk),
			.reset(reset),
			.load(load_r[i]),
			.cfg_in(cfg),
			.rx_bit(rx_bit[i]),
			.rx_word(rx_word[i]),
			.clr_tally(clr_edge),
			.stat(lstat[i]),
			.tally(tally[i])
		);
	end

	////////////////////////////////////////////////////////////////
	// Test interrupt source and latched flags
	logic [3:0] cond;
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			unique case (src_r)
				SRC_MISMATCH: cond[i] = lstat[i].mismatch;
				SRC_SEARCH: cond[i] = lstat[i].search;
				SRC_ERROR: cond[i] = lstat[i].err;
				SRC_SYNC: cond[i] = lstat[i].sync;
				SRC_ALIGN: cond[i] = align_r;
				default: cond[i] = 1'b0;
			endcase
		end
	end

	// New condition beats a clear in the same cycle
	wire logic [3:0] ltirq_nxt = (ltirq_r & ~{4{icc_r}}) | cond;
	// Only the rising alignment sets its sticky bit
	wire logic [4:0] ev = {align_r && !align_prev_r, cond & ~ltirq_r};
	wire logic [4:0] iclr = wr_iclr ? wbyte_r[4:0] : 5'h00;
	wire logic [4:0] ist_nxt = (ist_r & ~iclr) | ev;

	// Alignment comes from the link side, not this clock
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			align_r <= 1'b0;
			ecc_r <= 1'b0;
			ecc_prev_r <= 1'b0;
			align_prev_r <= 1'b0;
			icc_r <= 1'b0;
			ltirq_r <= 4'h0;
			ist_r <= 5'h00;
			irq_r <= 1'b0;
		end else begin
			s1_r <= align_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				align_r <= s3_r;
			end
			// Self-clearing: hardware drops them a cycle later
			ecc_r <= wr_irqc && wbyte_r[ECLR_BIT];
			ecc_prev_r <= ecc_r;
			align_prev_r <= align_r;
			icc_r <= wr_irqc && wbyte_r[ICLR_BIT];
			ltirq_r <= ltirq_nxt;
			ist_r <= ist_nxt;
			irq_r <= |(ist_nxt & ien_r);
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign irq = irq_r;

	////////////////////////////////////////////////////////////////
	a_reset_zero: assert property (@(posedge clk) $fell(reset) |->
		ctrl_r == RST_VAL && cptop_r == RST_VAL && thr_r == RST_VAL
		&& irqc_byte == RST_VAL)
		else $error("config not zero after reset");
	a_align_sync: assert property (@(posedge clk) disable iff (reset)
		$changed(align_r) |-> $past(s2_r) == $past(s3_r)
		&& align_r == $past(s3_r))
		else $error("alignment changed before stages agreed");
	a_irq_clear: assert property (@(posedge clk) disable iff (reset)
		icc_r && cond == 4'h0 |=> ltirq_r == 4'h0)
		else $error("latched interrupt survived clear");
	a_irq_hold: assert property (@(posedge clk) disable iff (reset)
		ltirq_r[0] && !icc_r |=> ltirq_r[0])
		else $error("latched interrupt dropped without clear");
	a_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
		ctrl_r[6] == 1'b0 && cptop_r[7:4] == 4'h0 && thr_r[7:3] == 5'h00)
		else $error("reserved bit became set");
	a_clr_pulse: assert property (@(posedge clk) disable iff (reset)
		wr_irqc && wbyte_r[ECLR_BIT] |=> ecc_r ##1 !ecc_r)
		else $error("error clear not a single pulse");
	a_write_resp: assert property (@(posedge clk) disable iff (reset)
		aw_take && w_take |=> ##1 bvalid_r)
		else $error("write response late");
	c_write: cover property (@(posedge clk) disable iff (reset)
		wr_ctrl ##1 bvalid_r);
	c_read: cover property (@(posedge clk) disable iff (reset)
		rvalid_r && rready);
	c_irq: cover property (@(posedge clk) disable iff (reset) $rose(irq_r));
endmodule : rpv_top

// ===== verification/rpv_link_src.sv
////////////////////////////////////////////////////////////////////////
// Incoming lanes: one test stream copied onto all four lanes
module rpv_link_src (
	input wire logic clk,
	input wire logic [2:0] order,
	input wire logic [19:0] word,
	input wire logic flip,
	output logic [3:0] rx_bit,
	output logic [3:0][19:0] rx_word
);
	timeunit 1ns;
	timeprecision 1ns;

	// Nonzero start, else the generator sticks at zero
	logic [30:0] lfsr_r = 31'h0000_0001;
	logic fb_nxt;

	// Feedback per order field value
	function automatic logic fb(input logic [30:0] s, input logic [2:0] o);
		case (o)
			3'h0: return s[6] ^ s[5];
			3'h1: return s[10] ^ s[8];
			3'h2: return s[22] ^ s[17];
			3'h3: return s[30] ^ s[27];
			3'h4, 3'h5: return s[14] ^ s[13];
			default: return s[19] ^ s[2];
		endcase
	endfunction : fb

	////////////////////////////////////////////////////////////////////////
	assign fb_nxt = fb(lfsr_r, order);

	// Flip corrupts one whole word on every lane
	always_ff @(posedge clk) begin
		lfsr_r <= {lfsr_r[29:0], fb_nxt};
		rx_bit <= {4{fb_nxt}};
		rx_word <= {4{word ^ {20{flip}}}};
	end
endmodule : rpv_link_src

// ===== verification/test_rpv_top.sv
////////////////////////////////////////////////////////////////////////
module test_rpv_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rpv_pkg::*;

	logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, align_pin, irq, flip;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb, rx_bit;
	logic [1:0] bresp, rresp;
	logic [3:0][19:0] rx_word;
	logic [2:0] ord;
	logic [19:0] word, p;
	int fail_count, n_tests;
	int cyc = 0;
	localparam logic [5:0] CFG [6] = '{IDX_CTRL, IDX_CPLO, IDX_CPMID,
		IDX_CPTOP, IDX_THR, IDX_IRQC};
	// Off, custom 20 bit, custom 16 bit, clock
	localparam logic [7:0] TCTL [4] = '{8'h00, 8'h83, 8'h03, 8'h02};
	localparam logic [7:0] TEXP [4] = '{8'h00, 8'h0F, 8'h00, 8'h00};

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	rpv_top uut (.clk(clk), .reset(reset), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .rx_bit(rx_bit), .rx_word(rx_word),
		.align_pin(align_pin), .irq(irq));

	rpv_link_src src (.clk(clk), .order(ord), .word(word), .flip(flip),
		.rx_bit(rx_bit), .rx_word(rx_word));

	////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		if (fail_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// Whole run needs well under this
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Writable bits per register; reserved bits stay zero
	function automatic logic [7:0] wmask(input logic [5:0] idx);
		case (idx)
			IDX_CTRL: return 8'hBF;
			IDX_CPTOP: return 8'h0F;
			IDX_THR: return 8'h07;
			IDX_IRQC: return 8'h07;
			default: return 8'hFF;
		endcase
	endfunction : wmask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d,
		input logic [1:0] er = RESP_OKAY);
		@(posedge clk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// No wait limit here: the bench timeout ends a hung write
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [31:0] exp,
		input logic [1:0] er = RESP_OKAY, input logic [31:0] msk = 32'hFFFFFFFF);
		@(posedge clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		v = rdata;
		chk(rdata & msk, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	initial begin
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		align_pin = 1'b0;
		flip = 1'b0;
		ord = 3'h0;
		word = 20'h0;
		reset = 1'b1;
		fail_count = 0;
		n_tests = 0;
		void'($urandom(32'h3d57));
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (CFG[i]) rd(CFG[i], 32'h0);
		foreach (CFG[i]) begin
			p = 20'($urandom);
			wr(CFG[i], p[7:0]);
			rd(CFG[i], {24'h0, p[7:0] & wmask(CFG[i])});
		end
		wr(6'h3F, 8'hFF, RESP_SLVERR);
		rd(6'h3F, 32'h0, RESP_SLVERR);
		// Every order, lanes fed the matching stream
		wr(IDX_THR, 8'h03);
		wr(IDX_LOAD, 8'h0F);
		for (int o = 0; o < 8; o++) begin
			ord <= 3'(o);
			wr(IDX_CTRL, {2'b00, 3'(o), 3'h1});
			repeat (100) @(posedge clk);
			wr(IDX_IRQC, 8'h10);
			repeat (40) @(posedge clk);
			rd(IDX_LSTAT, 32'h0);
			rd(IDX_TALLY, 32'h0);
		end
		// Held settings must outlive a register change
		wr(IDX_LOAD, 8'h00);
		wr(IDX_CTRL, 8'h00);
		wr(IDX_IRQC, 8'h10);
		ord <= 3'h0;
		repeat (40) @(posedge clk);
		rd(IDX_TALLY, 32'h0, RESP_OKAY, 32'h0);
		chk({31'h0, v != 32'h0}, 32'h1);
		// Second reset so no lane starts locked
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		p = 20'($urandom);
		wr(IDX_CPLO, p[7:0]);
		wr(IDX_CPMID, p[15:8]);
		wr(IDX_CPTOP, {4'h0, p[19:16]});
		wr(IDX_LOAD, 8'h0F);
		for (int k = 0; k < 4; k++) begin
			word <= (k == 3) ? CLK_PATTERN : p ^ 20'hF0000;
			wr(IDX_CTRL, TCTL[k]);
			repeat (40) @(posedge clk);
			rd(IDX_LSTAT, {24'h0, TEXP[k]});
		end
		// One bad word while locked on the clock pattern
		wr(IDX_IRQC, 8'h10);
		@(posedge clk);
		flip <= 1'b1;
		@(posedge clk);
		flip <= 1'b0;
		repeat (20) @(posedge clk);
		rd(IDX_TALLY, 32'h1);
		rd(IDX_LOAD, 32'hFF);
		rd(IDX_ISTAT, 32'h0F);
		chk({31'h0, irq}, 32'h0);
		wr(IDX_IEN, 8'h01);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(IDX_IEN, 8'h00);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(IDX_IEN, 8'h01);
		wr(IDX_IRQC, 8'h08);
		rd(IDX_LOAD, 32'h0F);
		wr(IDX_ICLR, 8'h0F);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rd(IDX_ISTAT, 32'h0);
		wr(IDX_IRQC, 8'h10);
		rd(IDX_TALLY, 32'h0);
		// Alignment status and its interrupt
		align_pin <= 1'b1;
		repeat (10) @(posedge clk);
		rd(IDX_IRQC, 32'h80);
		rd(IDX_ISTAT, 32'h10);
		wr(IDX_IEN, 8'h10);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(IDX_ICLR, 8'h10);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		// Alignment as source sets every latched flag
		wr(IDX_IRQC, {5'h00, SRC_ALIGN});
		rd(IDX_LOAD, 32'hFF);
		// Timing-only mode, sync pulses every 127 cycles
		// Flags cleared first so only sync pulses can set them
		wr(IDX_IRQC, {5'h01, SRC_SYNC});
		rd(IDX_LOAD, 32'h0F);
		wr(IDX_CTRL, 8'h04);
		repeat (300) @(posedge clk);
		rd(IDX_LOAD, 32'hFF);
		conclude();
	end
endmodule : test_rpv_top
